// ---- verilog/uesc_core.sv ----
// Endpoint status, select and set-status command logic of the device interface engine
`timescale 1ns/1ps

module uesc_core (
    // Clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    sys_rst,
    // Software command port
    input  wire logic                    cmd_wr,
    input  wire logic [7:0]              cmd_code,
    input  wire logic                    dat_wr,
    input  wire logic [7:0]              dat_wdata,
    input  wire logic                    dat_rd,
    output logic                         rd_valid,
    output logic [7:0]                   rd_data,
    // Software buffer traffic
    input  wire logic                    sw_fill,
    input  wire logic                    sw_drain,
    input  wire logic [3:0]              sw_ep,
    // Packet engine side
    input  wire logic                    tok_valid,
    input  wire uesc_pkg::uesc_tok_t     tok,
    input  wire logic                    in_acked,
    input  wire logic [3:0]              in_acked_ep,
    output logic                         rsp_valid,
    output uesc_pkg::uesc_rsp_t          rsp,
    // Configuration and status
    input  wire logic [9:0]              nak_int_en,
    output logic [9:0]                   endpoint_interrupt_status,
    output logic [9:0]                   ep_stalled,
    output logic [9:0]                   ep_data_toggle
);

    // Command state
    uesc_pkg::uesc_cmd_state_t cs_q;
    uesc_pkg::uesc_cmd_state_t cs_d;
    logic [3:0]                sel_ep_q;
    logic [3:0]                sel_ep_d;
    logic                      rd_valid_q;
    logic                      rd_valid_d;
    logic [7:0]                rd_data_q;
    logic [7:0]                rd_data_d;
    logic                      set_wr;
    logic                      clr_rd;

    // Endpoint state
    uesc_pkg::uesc_ep_t        ep_q [uesc_pkg::NUM_EP];
    uesc_pkg::uesc_ep_t        ep_d [uesc_pkg::NUM_EP];
    logic [7:0]                stat_byte [uesc_pkg::NUM_EP];
    logic [9:0]                full_v;
    logic [9:0]                empty_v;

    // Response state
    logic                      rsp_valid_q;
    logic                      rsp_valid_d;
    uesc_pkg::uesc_rsp_t       rsp_q;
    uesc_pkg::uesc_rsp_t       rsp_d;
    logic                      tok_ok;

    assign set_wr = dat_wr && (cs_q == uesc_pkg::CS_SEL_CLR || cs_q == uesc_pkg::CS_SET_ONLY);
    assign clr_rd = dat_rd && (cs_q == uesc_pkg::CS_SEL_CLR);
    assign tok_ok = tok_valid && (tok.ep <= uesc_pkg::EP_MAX);

    // Command decode and status read
    always_comb begin
        cs_d       = cs_q;
        sel_ep_d   = sel_ep_q;
        rd_valid_d = 1'b0;
        rd_data_d  = rd_data_q;
        if (cmd_wr) begin
            if (cmd_code <= uesc_pkg::OP_SEL_LAST) begin
                cs_d     = uesc_pkg::CS_SELECT;
                sel_ep_d = cmd_code[3:0];
            end else if (cmd_code >= uesc_pkg::OP_CLR_FIRST && cmd_code <= uesc_pkg::OP_CLR_LAST) begin
                cs_d     = uesc_pkg::CS_SEL_CLR;
                sel_ep_d = cmd_code[3:0];
            end else if (cmd_code > uesc_pkg::OP_CLR_LAST && cmd_code <= uesc_pkg::OP_SET_LAST) begin
                cs_d     = uesc_pkg::CS_SET_ONLY;
                sel_ep_d = cmd_code[3:0];
            end else begin
                cs_d = uesc_pkg::CS_IDLE;
            end
        end else begin
            case (cs_q)
                uesc_pkg::CS_IDLE: begin
                    cs_d = uesc_pkg::CS_IDLE;
                end
                uesc_pkg::CS_SELECT: begin
                    cs_d = uesc_pkg::CS_SELECT;
                end
                uesc_pkg::CS_SEL_CLR: begin
                    if (dat_rd) begin
                        cs_d = uesc_pkg::CS_SELECT;
                    end else if (dat_wr) begin
                        cs_d = uesc_pkg::CS_IDLE;
                    end
                end
                uesc_pkg::CS_SET_ONLY: begin
                    if (dat_wr) begin
                        cs_d = uesc_pkg::CS_IDLE;
                    end
                end
                default: begin
                    cs_d = uesc_pkg::CS_IDLE;
                end
            endcase
        end
        if (dat_rd && !cmd_wr) begin
            rd_valid_d = 1'b1;
            if (sel_ep_q <= uesc_pkg::EP_MAX && cs_q != uesc_pkg::CS_IDLE) begin
                rd_data_d = stat_byte[sel_ep_q];
            end else begin
                rd_data_d = 8'h00;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cs_q       <= uesc_pkg::CS_IDLE;
            sel_ep_q   <= 4'h0;
            rd_valid_q <= 1'b0;
            rd_data_q  <= 8'h00;
        end else begin
            cs_q       <= cs_d;
            sel_ep_q   <= sel_ep_d;
            rd_valid_q <= rd_valid_d;
            rd_data_q  <= rd_data_d;
        end
    end

    // Per-endpoint status
    for (genvar i = 0; i < uesc_pkg::NUM_EP; i++) begin : g_ep
        localparam logic [3:0] EPI     = 4'(i);
        localparam logic       IS_IN   = EPI[0];
        localparam logic       IS_CTRL = uesc_pkg::CTRL_EP_MASK[i];
        localparam logic       IS_DBL  = uesc_pkg::DBL_BUF_MASK[i];
        logic hit_tok;
        logic hit_wr;
        logic hit_clr;

        assign hit_tok    = tok_ok && !cmd_wr && tok.ep == EPI;
        assign hit_wr     = set_wr && !cmd_wr && sel_ep_q == EPI;
        assign hit_clr    = clr_rd && !cmd_wr && sel_ep_q == EPI;
        assign full_v[i]  = IS_DBL ? (ep_q[i].b1 && ep_q[i].b2) : ep_q[i].b1;
        assign empty_v[i] = !ep_q[i].b1;

        always_comb begin
            stat_byte[i]                      = 8'h00;
            stat_byte[i][uesc_pkg::ST_FE]     = (IS_IN && IS_DBL) ? (ep_q[i].b1 && ep_q[i].b2)
                                                : (ep_q[i].b1 || (IS_DBL && ep_q[i].b2));
            stat_byte[i][uesc_pkg::ST_STALL]  = ep_q[i].stall;
            stat_byte[i][uesc_pkg::ST_STP]    = ep_q[i].setup_received_flag;
            stat_byte[i][uesc_pkg::ST_PO]     = ep_q[i].po;
            stat_byte[i][uesc_pkg::ST_NAK]    = ep_q[i].nak;
            stat_byte[i][uesc_pkg::ST_B1]     = ep_q[i].b1;
            stat_byte[i][uesc_pkg::ST_B2]     = IS_DBL && ep_q[i].b2;
            stat_byte[i][uesc_pkg::ST_RSVD]   = 1'b0;
        end

        always_comb begin
            ep_d[i] = ep_q[i];
            // Clears first so that a same-cycle hardware event wins
            if (hit_clr) begin
                ep_d[i].intr = 1'b0;
                if (EPI == uesc_pkg::CTRL_OUT_EP) begin
                    ep_d[i].setup_received_flag = 1'b0;
                    ep_d[i].po  = 1'b0;
                end
            end
            if (hit_wr) begin
                ep_d[i].ext   = dat_wdata[uesc_pkg::SS_EXT_MSB:uesc_pkg::SS_EXT_LSB];
                ep_d[i].stall = dat_wdata[uesc_pkg::SS_STALL];
                ep_d[i].b1    = 1'b0;
                ep_d[i].b2    = 1'b0;
                ep_d[i].tog   = 1'b0;
            end
            if (sw_fill && sw_ep == EPI && IS_IN) begin
                if (!ep_d[i].b1) begin
                    ep_d[i].b1 = 1'b1;
                end else if (IS_DBL) begin
                    ep_d[i].b2 = 1'b1;
                end
            end
            if (sw_drain && sw_ep == EPI && !IS_IN) begin
                if (ep_d[i].b2) begin
                    ep_d[i].b2 = 1'b0;
                end else begin
                    ep_d[i].b1 = 1'b0;
                end
            end
            if (hit_tok) begin
                case (tok.kind)
                    uesc_pkg::TOK_SETUP: begin
                        if (IS_CTRL && !IS_IN) begin
                            ep_d[i].stall = 1'b0;
                            ep_d[i].po    = ep_q[i].b1 && !ep_q[i].stall;
                            ep_d[i].b1    = 1'b1;
                            ep_d[i].b2    = 1'b0;
                            ep_d[i].setup_received_flag   = 1'b1;
                            ep_d[i].nak   = 1'b0;
                            ep_d[i].intr  = 1'b1;
                            ep_d[i].tog   = 1'b1;
                        end
                    end
                    uesc_pkg::TOK_OUT: begin
                        if (!ep_q[i].stall && !IS_IN) begin
                            if (full_v[i]) begin
                                if (nak_int_en[i]) begin
                                    ep_d[i].nak = 1'b1;
                                end
                            end else begin
                                if (!ep_q[i].b1) begin
                                    ep_d[i].b1 = 1'b1;
                                end else begin
                                    ep_d[i].b2 = 1'b1;
                                end
                                ep_d[i].setup_received_flag  = 1'b0;
                                ep_d[i].nak  = 1'b0;
                                ep_d[i].intr = 1'b1;
                                ep_d[i].tog  = !ep_q[i].tog;
                            end
                        end
                    end
                    uesc_pkg::TOK_IN: begin
                        if (!ep_q[i].stall && IS_IN && empty_v[i] && nak_int_en[i]) begin
                            ep_d[i].nak = 1'b1;
                        end
                    end
                    default: begin
                        ep_d[i].nak = ep_q[i].nak;
                    end
                endcase
            end
            if (in_acked && in_acked_ep == EPI && IS_IN && ep_q[i].b1) begin
                if (ep_d[i].b2) begin
                    ep_d[i].b2 = 1'b0;
                end else begin
                    ep_d[i].b1 = 1'b0;
                end
                ep_d[i].nak  = 1'b0;
                ep_d[i].intr = 1'b1;
                ep_d[i].tog  = !ep_q[i].tog;
            end
        end

        always_ff @(posedge ref_clk or posedge sys_rst) begin
            if (sys_rst) begin
                ep_q[i] <= uesc_pkg::EP_RESET;
            end else begin
                ep_q[i] <= ep_d[i];
            end
        end

        assign endpoint_interrupt_status[i] = ep_q[i].intr;
        assign ep_stalled[i]                = ep_q[i].stall;
        assign ep_data_toggle[i]            = ep_q[i].tog;
    end

    // Handshake decision per token
    always_comb begin
        rsp_valid_d = 1'b0;
        rsp_d       = rsp_q;
        if (tok_ok && !cmd_wr) begin
            rsp_valid_d = 1'b1;
            rsp_d.kind  = uesc_pkg::RSP_ACK;
            rsp_d.toggle = ep_q[tok.ep].tog;
            case (tok.kind)
                uesc_pkg::TOK_SETUP: begin
                    rsp_d.kind   = uesc_pkg::RSP_ACK;
                    rsp_d.toggle = 1'b0;
                end
                uesc_pkg::TOK_OUT: begin
                    if (ep_q[tok.ep].stall) begin
                        rsp_d.kind = uesc_pkg::RSP_STALL;
                    end else if (full_v[tok.ep]) begin
                        rsp_d.kind = uesc_pkg::RSP_NAK;
                    end else begin
                        rsp_d.kind = uesc_pkg::RSP_ACK;
                    end
                end
                uesc_pkg::TOK_IN: begin
                    if (ep_q[tok.ep].stall) begin
                        rsp_d.kind = uesc_pkg::RSP_STALL;
                    end else if (empty_v[tok.ep]) begin
                        rsp_d.kind = uesc_pkg::RSP_NAK;
                    end else begin
                        rsp_d.kind = uesc_pkg::RSP_DATA;
                    end
                end
                default: begin
                    rsp_valid_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rsp_valid_q <= 1'b0;
            rsp_q       <= '{kind: uesc_pkg::RSP_ACK, toggle: 1'b0};
        end else begin
            rsp_valid_q <= rsp_valid_d;
            rsp_q       <= rsp_d;
        end
    end

    assign rd_valid  = rd_valid_q;
    assign rd_data   = rd_data_q;
    assign rsp_valid = rsp_valid_q;
    assign rsp       = rsp_q;

endmodule

// ---- verilog/uesc_pkg.sv ----
// Package with constants and types for the endpoint status command logic
package uesc_pkg;

    // Endpoint population
    localparam int unsigned NUM_EP       = 10;
    localparam logic [3:0]  EP_MAX       = 4'h9;
    localparam logic [3:0]  CTRL_OUT_EP  = 4'h0;
    localparam logic [9:0]  CTRL_EP_MASK = 10'h003;
    localparam logic [9:0]  DBL_BUF_MASK = 10'h3fc;

    // Command codes
    localparam logic [7:0] OP_SEL_FIRST    = 8'h00;
    localparam logic [7:0] OP_SEL_LAST     = 8'h09;
    localparam logic [7:0] OP_CLR_FIRST    = 8'h40;
    localparam logic [7:0] OP_CLR_LAST     = 8'h47;
    localparam logic [7:0] OP_SET_LAST     = 8'h49;

    // Status byte fields
    localparam int unsigned ST_FE    = 0;
    localparam int unsigned ST_STALL = 1;
    localparam int unsigned ST_STP   = 2;
    localparam int unsigned ST_PO    = 3;
    localparam int unsigned ST_NAK   = 4;
    localparam int unsigned ST_B1    = 5;
    localparam int unsigned ST_B2    = 6;
    localparam int unsigned ST_RSVD  = 7;

    // Set status byte fields
    localparam int unsigned SS_STALL   = 0;
    localparam int unsigned SS_EXT_LSB = 5;
    localparam int unsigned SS_EXT_MSB = 7;

    typedef enum logic [1:0] {
        TOK_SETUP,
        TOK_OUT,
        TOK_IN
    } uesc_tok_kind_t;

    typedef enum logic [1:0] {
        RSP_ACK,
        RSP_NAK,
        RSP_STALL,
        RSP_DATA
    } uesc_rsp_kind_t;

    typedef enum logic [1:0] {
        CS_IDLE,
        CS_SELECT,
        CS_SEL_CLR,
        CS_SET_ONLY
    } uesc_cmd_state_t;

    // Token from the packet engine
    typedef struct packed {
        logic [3:0]     ep;
        uesc_tok_kind_t kind;
    } uesc_tok_t;

    // Handshake decision for the packet engine
    typedef struct packed {
        uesc_rsp_kind_t kind;
        logic           toggle;
    } uesc_rsp_t;

    // Per-endpoint state
    typedef struct packed {
        logic       stall;
        logic       b1;
        logic       b2;
        logic       setup_received_flag;
        logic       po;
        logic       nak;
        logic       intr;
        logic       tog;
        logic [2:0] ext;
    } uesc_ep_t;

    localparam uesc_ep_t EP_RESET = '{stall: 1'b0, b1: 1'b0, b2: 1'b0, setup_received_flag: 1'b0, po: 1'b0,
                                     nak: 1'b0, intr: 1'b0, tog: 1'b0, ext: 3'h0};

endpackage

// ---- sim/uesc_core_chk.sv ----
// Checker of the endpoint status command logic ports
`timescale 1ns/1ps

module uesc_core_chk (
    // Clock and reset
    input wire logic                    ref_clk,
    input wire logic                    sys_rst,
    // Command port
    input wire logic                    cmd_wr,
    input wire logic [7:0]              cmd_code,
    input wire logic                    dat_wr,
    input wire logic [7:0]              dat_wdata,
    input wire logic                    dat_rd,
    input wire logic                    rd_valid,
    input wire logic [7:0]              rd_data,
    // Packet engine side
    input wire logic                    tok_valid,
    input wire uesc_pkg::uesc_tok_t     tok,
    input wire logic                    in_acked,
    input wire logic                    rsp_valid,
    input wire uesc_pkg::uesc_rsp_t     rsp,
    // Status
    input wire logic [9:0]              endpoint_interrupt_status,
    input wire logic [9:0]              ep_stalled,
    input wire logic [9:0]              ep_data_toggle
);
    logic [3:0] ep_q;
    logic       set_q;
    logic       clr_q;
    logic       tgl_q;
    logic       tk;
    assign tk = tok_valid && !cmd_wr && tok.ep <= uesc_pkg::EP_MAX;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ep_q  <= 4'h0;
            set_q <= 1'b0;
            clr_q <= 1'b0;
            tgl_q <= 1'b0;
        end else begin
            if (cmd_wr) begin
                ep_q  <= cmd_code[3:0];
                set_q <= cmd_code >= uesc_pkg::OP_CLR_FIRST && cmd_code <= uesc_pkg::OP_SET_LAST;
                clr_q <= cmd_code >= uesc_pkg::OP_CLR_FIRST && cmd_code <= uesc_pkg::OP_CLR_LAST;
            end else if (dat_wr || dat_rd) begin
                set_q <= 1'b0;
                clr_q <= 1'b0;
            end
            if (tk) begin
                tgl_q <= ep_data_toggle[tok.ep];
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_rd_answer: assert property (dat_rd && !cmd_wr |=> rd_valid) else $error("read not answered");
    a_rd_only: assert property (rd_valid |-> $past(dat_rd && !cmd_wr)) else $error("stray read answer");
    a_rsp_answer: assert property (tk |=> rsp_valid) else $error("token not answered");
    a_rsp_only: assert property (rsp_valid |-> $past(tk)) else $error("stray response");
    a_rsvd_zero: assert property (rd_valid |-> rd_data[7] == 1'b0) else $error("reserved bit set");
    a_setup_unstall: assert property (tk && tok.kind == uesc_pkg::TOK_SETUP && tok.ep == 4'h0
        |=> !ep_stalled[0]) else $error("setup left stall");
    a_stall_write: assert property (dat_wr && !cmd_wr && set_q && !tok_valid && !in_acked
        |=> ep_stalled[ep_q] == $past(dat_wdata[0]) && !ep_data_toggle[ep_q]) else $error("set status wrong");
    a_int_kept: assert property (dat_wr && !cmd_wr && set_q && !tok_valid && !in_acked
        |=> $stable(endpoint_interrupt_status)) else $error("interrupt changed by set status");
    a_clr_int: assert property (dat_rd && !cmd_wr && clr_q && !tok_valid && !in_acked
        |=> !endpoint_interrupt_status[ep_q]) else $error("interrupt not cleared");
    a_data_toggle: assert property (rsp_valid && rsp.kind == uesc_pkg::RSP_DATA
        |-> rsp.toggle == tgl_q) else $error("wrong data toggle");

    c_setup: cover property (tk && tok.kind == uesc_pkg::TOK_SETUP);
    c_nak: cover property (rsp_valid && rsp.kind == uesc_pkg::RSP_NAK);
    c_stall: cover property (dat_wr && set_q && dat_wdata[0]);
    c_data: cover property (rsp_valid && rsp.kind == uesc_pkg::RSP_DATA);
endmodule

bind uesc_core uesc_core_chk u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .cmd_wr(cmd_wr), .cmd_code(cmd_code),
    .dat_wr(dat_wr), .dat_wdata(dat_wdata), .dat_rd(dat_rd), .rd_valid(rd_valid), .rd_data(rd_data),
    .tok_valid(tok_valid), .tok(tok), .in_acked(in_acked), .rsp_valid(rsp_valid), .rsp(rsp),
    .endpoint_interrupt_status(endpoint_interrupt_status), .ep_stalled(ep_stalled),
    .ep_data_toggle(ep_data_toggle));

// ---- sim/uesc_host.sv ----
// Host side model issuing tokens and handshakes to the endpoint logic
`timescale 1ns/1ps

module uesc_host (
    // Clock
    input wire logic                    ref_clk,
    // Token and handshake lines
    output logic                        tok_valid,
    output uesc_pkg::uesc_tok_t         tok,
    output logic                        in_acked,
    output logic [3:0]                  in_acked_ep,
    // Answer from the device
    input wire logic                    rsp_valid,
    input wire uesc_pkg::uesc_rsp_t     rsp
);
    initial begin
        tok_valid   = 1'b0;
        tok         = '{ep: 4'ha, kind: uesc_pkg::TOK_IN};
        in_acked    = 1'b0;
        in_acked_ep = 4'ha;
    end

    // Send one token, idle ep lines show the inverse afterwards
    task automatic send(input uesc_pkg::uesc_tok_kind_t k, input logic [3:0] e, output logic v,
                        output uesc_pkg::uesc_rsp_t r);
        @(posedge ref_clk);
        tok_valid <= 1'b1;
        tok       <= '{ep: e, kind: k};
        @(posedge ref_clk);
        tok_valid <= 1'b0;
        tok.ep    <= ~e;
        #1;
        v = rsp_valid;
        r = rsp;
    endtask

    // Acknowledge data sent on an IN endpoint
    task automatic ack_in(input logic [3:0] e);
        @(posedge ref_clk);
        in_acked    <= 1'b1;
        in_acked_ep <= e;
        @(posedge ref_clk);
        in_acked    <= 1'b0;
        in_acked_ep <= ~e;
        #1;
    endtask
endmodule

// ---- sim/usb_endpoint_status_commands_bench.sv ----
// Self-checking bench of the endpoint status command logic
`timescale 1ns/1ps

`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin errors++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end

module usb_endpoint_status_commands_bench;
    logic ref_clk = 1'b0, sys_rst = 1'b1, cmd_wr = 1'b0, dat_wr = 1'b0, dat_rd = 1'b0;
    logic [7:0] cmd_code = 8'h00, dat_wdata = 8'h00;
    logic sw_fill = 1'b0, sw_drain = 1'b0, tok_valid, in_acked, rd_valid, rsp_valid, v;
    logic [3:0] sw_ep = 4'h0, in_acked_ep;
    logic [9:0] nak_int_en = 10'h00c, endpoint_interrupt_status, ep_stalled, ep_data_toggle, isnap;
    logic [7:0] rd_data, d;
    uesc_pkg::uesc_tok_t tok;
    uesc_pkg::uesc_rsp_t rsp, r;
    int errors = 0;
    int checks_done = 0;

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    uesc_core u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .cmd_wr(cmd_wr), .cmd_code(cmd_code),
        .dat_wr(dat_wr), .dat_wdata(dat_wdata), .dat_rd(dat_rd), .rd_valid(rd_valid), .rd_data(rd_data),
        .sw_fill(sw_fill), .sw_drain(sw_drain), .sw_ep(sw_ep), .tok_valid(tok_valid), .tok(tok),
        .in_acked(in_acked), .in_acked_ep(in_acked_ep), .rsp_valid(rsp_valid), .rsp(rsp),
        .nak_int_en(nak_int_en), .endpoint_interrupt_status(endpoint_interrupt_status),
        .ep_stalled(ep_stalled), .ep_data_toggle(ep_data_toggle));

    uesc_host u_host (.ref_clk(ref_clk), .tok_valid(tok_valid), .tok(tok), .in_acked(in_acked),
        .in_acked_ep(in_acked_ep), .rsp_valid(rsp_valid), .rsp(rsp));

    task automatic cmd(input logic [7:0] c);
        @(posedge ref_clk);
        cmd_wr   <= 1'b1;
        cmd_code <= c;
        @(posedge ref_clk);
        cmd_wr   <= 1'b0;
        cmd_code <= ~c;
    endtask

    // One status byte read after a command, as software must
    task automatic rd(input logic [7:0] c, output logic [7:0] q);
        cmd(c);
        @(posedge ref_clk);
        dat_rd <= 1'b1;
        @(posedge ref_clk);
        dat_rd <= 1'b0;
        #1;
        `CHK("rd_valid", 1'b1, rd_valid);
        q = rd_data;
    endtask

    task automatic wr(input logic [7:0] c, input logic [7:0] b);
        cmd(c);
        @(posedge ref_clk);
        dat_wr    <= 1'b1;
        dat_wdata <= b;
        @(posedge ref_clk);
        dat_wr    <= 1'b0;
        dat_wdata <= ~b;
        #1;
    endtask

    task automatic sw(input logic fill, input logic [3:0] e);
        @(posedge ref_clk);
        sw_fill  <= fill;
        sw_drain <= !fill;
        sw_ep    <= e;
        @(posedge ref_clk);
        sw_fill  <= 1'b0;
        sw_drain <= 1'b0;
        sw_ep    <= ~e;
    endtask

    task automatic t_reset_state;
        rd(8'h00, d);
        `CHK("ep0 status", 8'h00, d);
        `CHK("stalled", 10'h000, ep_stalled);
        rd(8'h20, d);
        `CHK("unknown code read", 8'h00, d);
        u_host.send(uesc_pkg::TOK_OUT, 4'hf, v, r);
        `CHK("ep out of range", 1'b0, v);
    endtask

    task automatic t_setup_flags;
        u_host.send(uesc_pkg::TOK_SETUP, 4'h0, v, r);
        `CHK("setup ack", uesc_pkg::RSP_ACK, r.kind);
        `CHK("ep0 int", 1'b1, endpoint_interrupt_status[0]);
        rd(8'h40, d);
        `CHK("ep0 after setup", 8'h25, d);
        `CHK("ep0 int cleared", 1'b0, endpoint_interrupt_status[0]);
        rd(8'h00, d);
        `CHK("ep0 flags cleared", 8'h21, d);
        u_host.send(uesc_pkg::TOK_SETUP, 4'h0, v, r);
        rd(8'h00, d);
        `CHK("ep0 overwritten", 8'h2d, d);
        sw(1'b0, 4'h0);
        rd(8'h40, d);
        `CHK("ep0 drained", 8'h0c, d);
        rd(8'h00, d);
        `CHK("ep0 clear", 8'h00, d);
    endtask

    task automatic t_out_nak;
        u_host.send(uesc_pkg::TOK_OUT, 4'h2, v, r);
        u_host.send(uesc_pkg::TOK_OUT, 4'h2, v, r);
        u_host.send(uesc_pkg::TOK_OUT, 4'h2, v, r);
        `CHK("out full nak", uesc_pkg::RSP_NAK, r.kind);
        rd(8'h02, d);
        `CHK("ep2 nak flag", 8'h71, d);
        sw(1'b0, 4'h2);
        u_host.send(uesc_pkg::TOK_OUT, 4'h2, v, r);
        `CHK("out ack", uesc_pkg::RSP_ACK, r.kind);
        rd(8'h02, d);
        `CHK("ep2 nak cleared", 8'h61, d);
    endtask

    task automatic t_in_nak;
        u_host.send(uesc_pkg::TOK_IN, 4'h3, v, r);
        `CHK("in empty nak", uesc_pkg::RSP_NAK, r.kind);
        sw(1'b1, 4'h3);
        rd(8'h03, d);
        `CHK("ep3 one full", 8'h30, d);
        sw(1'b1, 4'h3);
        rd(8'h03, d);
        `CHK("ep3 both full", 8'h71, d);
        u_host.send(uesc_pkg::TOK_IN, 4'h3, v, r);
        `CHK("in data", {uesc_pkg::RSP_DATA, 1'b0}, r);
        u_host.ack_in(4'h3);
        rd(8'h03, d);
        `CHK("ep3 nak cleared", 8'h00, d & 8'h11);
        `CHK("ep3 toggle", 1'b1, ep_data_toggle[3]);
    endtask

    task automatic t_stall;
        isnap = endpoint_interrupt_status;
        wr(8'h43, 8'h01);
        `CHK("ep3 stalled", 1'b1, ep_stalled[3]);
        `CHK("ep3 toggle reset", 1'b0, ep_data_toggle[3]);
        `CHK("int kept", isnap, endpoint_interrupt_status);
        rd(8'h03, d);
        `CHK("ep3 flushed", 8'h02, d & 8'h63);
        wr(8'h43, 8'h00);
        `CHK("ep3 unstalled", 1'b0, ep_stalled[3]);
        sw(1'b1, 4'h3);
        wr(8'h43, 8'h00);
        rd(8'h03, d);
        `CHK("ep3 reinit", 8'h00, d & 8'h63);
        wr(8'h42, 8'hfe);
        rd(8'h02, d);
        `CHK("ep2 set status", 8'h00, d & 8'h63);
        `CHK("ep2 ignored bits", 8'h00, d & 8'h1e);
    endtask

    // Set status codes past the clear range, stall answer, NAK without its interrupt enabled
    task automatic t_set_only;
        wr(8'h49, 8'h01);
        `CHK("ep9 stalled", 1'b1, ep_stalled[9]);
        `CHK("ep9 int kept", 1'b0, endpoint_interrupt_status[9]);
        u_host.send(uesc_pkg::TOK_IN, 4'h9, v, r);
        `CHK("ep9 stall answer", uesc_pkg::RSP_STALL, r.kind);
        u_host.send(uesc_pkg::TOK_IN, 4'h5, v, r);
        `CHK("ep5 empty nak", uesc_pkg::RSP_NAK, r.kind);
        rd(8'h05, d);
        `CHK("ep5 no nak flag", 8'h00, d & 8'h10);
    endtask

    task automatic t_setup_unstall;
        wr(8'h40, 8'h01);
        `CHK("ep0 stalled", 1'b1, ep_stalled[0]);
        u_host.send(uesc_pkg::TOK_SETUP, 4'h0, v, r);
        `CHK("ep0 auto unstall", 1'b0, ep_stalled[0]);
        rd(8'h40, d);
        `CHK("ep0 after reinit", 8'h25, d);
        wr(8'h40, 8'h01);
        `CHK("ep0 restalled", 1'b1, ep_stalled[0]);
    endtask

    // Reset in mid-run drops stall and interrupt state
    task automatic t_mid_reset;
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        #1;
        `CHK("stalled after reset", 10'h000, ep_stalled);
        `CHK("int after reset", 10'h000, endpoint_interrupt_status);
        rd(8'h00, d);
        `CHK("ep0 after reset", 8'h00, d);
    endtask

    task automatic close_out;
        $display("checks_done %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_reset_state();
        t_setup_flags();
        t_out_nak();
        t_in_nak();
        t_stall();
        t_set_only();
        t_setup_unstall();
        t_mid_reset();
        close_out();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        close_out();
    end
endmodule
